//--- shared/dci_pkg.sv
// constants shared by the debug command interpreter
package dci_pkg;
    localparam logic [7:0] CMD_REV      = 8'h00;
    localparam logic [7:0] CMD_WCNT     = 8'h01;
    localparam logic [7:0] CMD_RSTAT    = 8'h02;
    localparam logic [7:0] CMD_RCNT     = 8'h03;
    localparam logic [7:0] CMD_WCTL     = 8'h04;
    localparam logic [7:0] CMD_RCTL     = 8'h05;
    localparam logic [7:0] CMD_WPC      = 8'h06;
    localparam logic [7:0] CMD_RPC      = 8'h07;
    localparam logic [7:0] CMD_WREG     = 8'h08;
    localparam logic [7:0] CMD_RREG     = 8'h09;
    localparam logic [7:0] CMD_WPROG    = 8'h0A;
    localparam logic [7:0] CMD_RPROG    = 8'h0B;
    localparam logic [7:0] CMD_WDATA    = 8'h0C;
    localparam logic [7:0] CMD_RDATA    = 8'h0D;
    localparam logic [7:0] CMD_CRC      = 8'h0E;
    localparam logic [7:0] CMD_STEP     = 8'h10;
    localparam logic [7:0] CMD_STUFF    = 8'h11;
    localparam logic [7:0] CMD_EXEC     = 8'h12;
    localparam logic [7:0] CMD_BAUD     = 8'h1B;

    localparam logic [15:0] ALL_ONES16  = 16'hFFFF;
    localparam logic [7:0]  ALL_ONES8   = 8'hFF;
    localparam logic [16:0] SIZE8_ZERO  = 17'h00100;
    localparam logic [16:0] SIZE16_ZERO = 17'h10000;
    localparam logic [15:0] CRC_SEED    = 16'hFFFF;
    // reflected form of x^16+x^12+x^5+1, lsb shifted first
    localparam logic [15:0] CRC_POLY_R  = 16'h8408;

    localparam int CTL_HALT_BIT = 7;
    localparam int STS_IDLE_BIT = 7;
    localparam int STS_HALT_BIT = 6;
    localparam int STS_RP_BIT   = 5;

    // memory space selector on the access port
    localparam logic [1:0] SPACE_REG  = 2'h0;
    localparam logic [1:0] SPACE_PROG = 2'h1;
    localparam logic [1:0] SPACE_DATA = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_ARG   = 4'h1,
        ST_DO    = 4'h2,
        ST_WDAT  = 4'h3,
        ST_RDAT  = 4'h4,
        ST_MEM   = 4'h5,
        ST_SEND  = 4'h6,
        ST_CRC   = 4'h7,
        ST_CRCQ  = 4'h8,
        ST_EXEC  = 4'h9
    } dci_state_type;
endpackage : dci_pkg

//--- logic/dci_crc16.sv
// byte-wide crc engine, lsb of each byte first
module dci_crc16 (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        init,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    output logic      [15:0] crc
);
    logic [15:0] crc_ff;
    logic [15:0] nxt_crc;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0]  d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ dci_pkg::CRC_POLY_R;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction : crc_step

    assign nxt_crc = init ? dci_pkg::CRC_SEED : crc_step(crc_ff, byte_data);
    assign crc     = crc_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            crc_ff <= dci_pkg::CRC_SEED;
        end else if (init || byte_valid) begin
            crc_ff <= nxt_crc;
        end
    end
endmodule : dci_crc16

//--- logic/dci_interp.sv
// debug command interpreter: byte commands in, replies and cpu/memory actions out
module dci_interp #(
    parameter logic [15:0] REVISION_ID = 16'h0100, // arbitrary value
    parameter logic [11:0] PERIPH_BASE = 12'hF00,
    parameter int          PROG_SIZE   = 16384
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        link_break,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             rx_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic        tx_ready,
    input  wire logic        read_protect_option,
    input  wire logic        flash_unlocked,
    input  wire logic        cpu_idle,
    input  wire logic        cpu_halt_mode,
    input  wire logic        hw_halt_set,
    input  wire logic [15:0] baud_reload,
    input  wire logic [15:0] debug_down_counter,
    output logic             cntr_load,
    output logic      [15:0] cntr_wdata,
    input  wire logic [15:0] program_counter,
    output logic             pc_load,
    output logic      [15:0] pc_wdata,
    output logic             debug_halt_bit,
    output logic      [7:0]  debugger_control_reg,
    output logic             cpu_step,
    output logic             cpu_stuff,
    output logic      [7:0]  stuff_opcode,
    input  wire logic [2:0]  exec_len,
    output logic             exec_valid,
    output logic             exec_first,
    output logic      [7:0]  exec_byte,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [1:0]  mem_space,
    output logic      [15:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [7:0]  mem_rdata
);
    if (PROG_SIZE < 1 || PROG_SIZE > 65536) begin : g_bad_size
        $error("PROG_SIZE must be 1..65536");
    end

    dci_pkg::dci_state_type state_ff;
    dci_pkg::dci_state_type nxt_state;
    logic [7:0]  cmd_ff;
    logic [31:0] hdr_ff;
    logic [2:0]  argn_ff;
    logic [15:0] addr_ff;
    logic [16:0] cnt_ff;
    logic [15:0] resp_ff;
    logic [1:0]  nresp_ff;
    logic [7:0]  ctl_ff;
    logic [7:0]  wdat_ff;
    logic        we_ff;
    logic [1:0]  space_ff;
    logic [2:0]  xrem_ff;
    logic        xfirst_ff;
    logic        cntr_load_ff;
    logic        pc_load_ff;
    logic        step_ff;
    logic        stuff_ff;

    logic        rx_take;
    logic        tx_take;
    logic        in_dbg;
    logic        rp;
    logic [2:0]  arg_count;
    logic        periph;
    logic        access_ok;
    logic        cpu_ok;
    logic [7:0]  status_byte;
    logic [16:0] size8;
    logic [16:0] size16;
    logic        crc_init;
    logic        crc_feed;
    logic [15:0] crc_val;

    assign in_dbg   = ctl_ff[dci_pkg::CTL_HALT_BIT];
    assign rp       = read_protect_option;
    assign cpu_ok   = in_dbg && !rp;
    assign rx_ready = (state_ff == dci_pkg::ST_IDLE) || (state_ff == dci_pkg::ST_ARG)
                    || (state_ff == dci_pkg::ST_WDAT) || (state_ff == dci_pkg::ST_EXEC);
    assign rx_take  = rx_valid && rx_ready;
    assign tx_valid = (state_ff == dci_pkg::ST_SEND);
    assign tx_data  = resp_ff[15:8];
    assign tx_take  = tx_valid && tx_ready;
    assign mem_req  = (state_ff == dci_pkg::ST_MEM);

    // header bytes per command; 12h is sized by the opcode instead
    assign arg_count = (rx_data == dci_pkg::CMD_WCNT)  ? 3'd2 :
                       (rx_data == dci_pkg::CMD_WCTL)  ? 3'd1 :
                       (rx_data == dci_pkg::CMD_WPC)   ? 3'd2 :
                       (rx_data == dci_pkg::CMD_WREG)  ? 3'd3 :
                       (rx_data == dci_pkg::CMD_RREG)  ? 3'd3 :
                       (rx_data == dci_pkg::CMD_STUFF) ? 3'd1 :
                       (rx_data >= dci_pkg::CMD_WPROG
                        && rx_data <= dci_pkg::CMD_RDATA) ? 3'd4 : 3'd0;

    assign periph = (addr_ff[11:0] >= PERIPH_BASE);
    // per-command gate on memory traffic
    assign access_ok =
        (cmd_ff == dci_pkg::CMD_WREG)  ? in_dbg && (!rp || periph) :
        (cmd_ff == dci_pkg::CMD_RREG)  ? in_dbg && (!rp || periph) :
        (cmd_ff == dci_pkg::CMD_WPROG) ? cpu_ok && flash_unlocked :
        (cmd_ff == dci_pkg::CMD_RPROG) ? cpu_ok :
        (cmd_ff == dci_pkg::CMD_WDATA) ? cpu_ok :
        (cmd_ff == dci_pkg::CMD_RDATA) ? in_dbg : 1'b0;

    assign status_byte = {in_dbg | cpu_idle, cpu_halt_mode, rp, 5'h00};
    assign size8  = (hdr_ff[7:0] == 8'h00) ? dci_pkg::SIZE8_ZERO
                                           : {9'h000, hdr_ff[7:0]};
    assign size16 = (hdr_ff[15:0] == 16'h0000) ? dci_pkg::SIZE16_ZERO
                                               : {1'b0, hdr_ff[15:0]};
    assign crc_init = (state_ff == dci_pkg::ST_DO) && (cmd_ff == dci_pkg::CMD_CRC);
    assign crc_feed = mem_req && mem_ack && (cmd_ff == dci_pkg::CMD_CRC);

    dci_crc16 u_crc (
        .clock      (clock),
        .arst_n     (arst_n),
        .init       (crc_init),
        .byte_valid (crc_feed),
        .byte_data  (mem_rdata),
        .crc        (crc_val)
    );

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            dci_pkg::ST_IDLE: begin
                if (rx_take) begin
                    if (rx_data == dci_pkg::CMD_EXEC) begin
                        nxt_state = dci_pkg::ST_EXEC;
                    end else if (arg_count == 3'd0) begin
                        nxt_state = dci_pkg::ST_DO;
                    end else begin
                        nxt_state = dci_pkg::ST_ARG;
                    end
                end
            end
            dci_pkg::ST_ARG: begin
                if (rx_take && argn_ff == 3'd1) begin
                    nxt_state = dci_pkg::ST_DO;
                end
            end
            dci_pkg::ST_DO: begin
                case (cmd_ff)
                    dci_pkg::CMD_REV, dci_pkg::CMD_RSTAT, dci_pkg::CMD_RCNT,
                    dci_pkg::CMD_RCTL, dci_pkg::CMD_RPC, dci_pkg::CMD_BAUD: begin
                        nxt_state = dci_pkg::ST_SEND;
                    end
                    dci_pkg::CMD_WREG, dci_pkg::CMD_WPROG,
                    dci_pkg::CMD_WDATA: begin
                        nxt_state = dci_pkg::ST_WDAT;
                    end
                    dci_pkg::CMD_RREG, dci_pkg::CMD_RPROG,
                    dci_pkg::CMD_RDATA: begin
                        nxt_state = dci_pkg::ST_RDAT;
                    end
                    dci_pkg::CMD_CRC: begin
                        nxt_state = in_dbg ? dci_pkg::ST_CRC : dci_pkg::ST_SEND;
                    end
                    default: begin
                        nxt_state = dci_pkg::ST_IDLE;
                    end
                endcase
            end
            dci_pkg::ST_WDAT: begin
                if (rx_take) begin
                    if (access_ok) begin
                        nxt_state = dci_pkg::ST_MEM;
                    end else if (cnt_ff == 17'd1) begin
                        nxt_state = dci_pkg::ST_IDLE;
                    end
                end
            end
            dci_pkg::ST_RDAT: begin
                nxt_state = access_ok ? dci_pkg::ST_MEM : dci_pkg::ST_SEND;
            end
            dci_pkg::ST_MEM: begin
                if (mem_ack) begin
                    if (cmd_ff == dci_pkg::CMD_CRC) begin
                        nxt_state = (cnt_ff == 17'd1) ? dci_pkg::ST_CRCQ : dci_pkg::ST_CRC;
                    end else if (we_ff) begin
                        nxt_state = (cnt_ff == 17'd0) ? dci_pkg::ST_IDLE
                                                      : dci_pkg::ST_WDAT;
                    end else begin
                        nxt_state = dci_pkg::ST_SEND;
                    end
                end
            end
            dci_pkg::ST_SEND: begin
                if (tx_take && nresp_ff == 2'd1) begin
                    nxt_state = (cnt_ff == 17'd0) ? dci_pkg::ST_IDLE
                                                  : dci_pkg::ST_RDAT;
                end
            end
            dci_pkg::ST_CRC: begin
                nxt_state = dci_pkg::ST_MEM;
            end
            dci_pkg::ST_CRCQ: begin
                nxt_state = dci_pkg::ST_SEND;
            end
            dci_pkg::ST_EXEC: begin
                if (rx_take && !xfirst_ff && xrem_ff == 3'd1) begin
                    nxt_state = dci_pkg::ST_IDLE;
                end else if (rx_take && xfirst_ff && exec_len <= 3'd1) begin
                    nxt_state = dci_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = dci_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= dci_pkg::ST_IDLE;
        end else if (link_break) begin
            state_ff <= dci_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // command byte and header shift
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmd_ff  <= 8'h00;
            hdr_ff  <= 32'h0000_0000;
            argn_ff <= 3'd0;
        end else if (rx_take && state_ff == dci_pkg::ST_IDLE) begin
            cmd_ff  <= rx_data;
            argn_ff <= arg_count;
        end else if (rx_take && state_ff == dci_pkg::ST_ARG) begin
            hdr_ff  <= {hdr_ff[23:0], rx_data};   // high bytes first
            argn_ff <= argn_ff - 3'd1;
        end
    end

    // control register; hardware halt request wins over a host write
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctl_ff <= 8'h00;
        end else begin
            if (state_ff == dci_pkg::ST_DO && cmd_ff == dci_pkg::CMD_WCTL) begin
                ctl_ff <= hdr_ff[7:0];
            end
            if (hw_halt_set) begin
                ctl_ff[dci_pkg::CTL_HALT_BIT] <= 1'b1;
            end
        end
    end

    // addressing, counting and reply buffer
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            addr_ff  <= 16'h0000;
            cnt_ff   <= 17'd0;
            resp_ff  <= 16'h0000;
            nresp_ff <= 2'd0;
            wdat_ff  <= 8'h00;
            we_ff    <= 1'b0;
            space_ff <= dci_pkg::SPACE_REG;
        end else if (link_break) begin
            cnt_ff   <= 17'd0;
            nresp_ff <= 2'd0;
        end else begin
            case (state_ff)
                dci_pkg::ST_DO: begin
                    nresp_ff <= 2'd2;
                    cnt_ff   <= 17'd0;
                    we_ff    <= 1'b0;
                    space_ff <= (cmd_ff <= dci_pkg::CMD_RREG) ? dci_pkg::SPACE_REG :
                                (cmd_ff <= dci_pkg::CMD_RPROG) ? dci_pkg::SPACE_PROG :
                                (cmd_ff == dci_pkg::CMD_CRC) ? dci_pkg::SPACE_PROG :
                                dci_pkg::SPACE_DATA;
                    case (cmd_ff)
                        dci_pkg::CMD_REV: begin
                            resp_ff <= REVISION_ID;
                        end
                        dci_pkg::CMD_RSTAT: begin
                            resp_ff  <= {status_byte, 8'h00};
                            nresp_ff <= 2'd1;
                        end
                        dci_pkg::CMD_RCNT: begin
                            resp_ff <= in_dbg ? ~debug_down_counter
                                              : dci_pkg::ALL_ONES16;
                        end
                        dci_pkg::CMD_RCTL: begin
                            resp_ff  <= {ctl_ff, 8'h00};
                            nresp_ff <= 2'd1;
                        end
                        dci_pkg::CMD_RPC: begin
                            resp_ff <= cpu_ok ? program_counter
                                              : dci_pkg::ALL_ONES16;
                        end
                        dci_pkg::CMD_BAUD: begin
                            resp_ff <= baud_reload;
                        end
                        dci_pkg::CMD_CRC: begin
                            resp_ff <= dci_pkg::ALL_ONES16;
                            addr_ff <= 16'h0000;
                            cnt_ff  <= 17'(PROG_SIZE);
                        end
                        dci_pkg::CMD_WREG, dci_pkg::CMD_RREG: begin
                            addr_ff <= {4'h0, hdr_ff[19:8]};
                            cnt_ff  <= size8;
                        end
                        default: begin
                            addr_ff <= hdr_ff[31:16];
                            cnt_ff  <= size16;
                        end
                    endcase
                end
                dci_pkg::ST_WDAT: begin
                    if (rx_take) begin
                        wdat_ff <= rx_data;
                        we_ff   <= 1'b1;
                        cnt_ff  <= cnt_ff - 17'd1;
                        if (!access_ok) begin
                            addr_ff <= addr_ff + 16'd1;
                        end
                    end
                end
                dci_pkg::ST_RDAT: begin
                    cnt_ff   <= cnt_ff - 17'd1;
                    nresp_ff <= 2'd1;
                    we_ff    <= 1'b0;
                    resp_ff  <= {dci_pkg::ALL_ONES8, 8'h00};
                    if (!access_ok) begin
                        addr_ff <= addr_ff + 16'd1;
                    end
                end
                dci_pkg::ST_MEM: begin
                    if (mem_ack) begin
                        addr_ff <= addr_ff + 16'd1;
                        if (cmd_ff == dci_pkg::CMD_CRC) begin
                            cnt_ff <= cnt_ff - 17'd1;
                        end else if (!we_ff) begin
                            resp_ff <= {mem_rdata, 8'h00};
                        end
                    end
                end
                dci_pkg::ST_CRCQ: begin
                    resp_ff  <= ~crc_val;
                    nresp_ff <= 2'd2;
                end
                dci_pkg::ST_SEND: begin
                    if (tx_take) begin
                        resp_ff  <= {resp_ff[7:0], 8'h00};
                        nresp_ff <= nresp_ff - 2'd1;
                    end
                end
                default: begin
                    nresp_ff <= nresp_ff;
                end
            endcase
        end
    end

    // single-cycle strobes to the counter and the cpu
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cntr_load_ff <= 1'b0;
            pc_load_ff   <= 1'b0;
            step_ff      <= 1'b0;
            stuff_ff     <= 1'b0;
        end else begin
            cntr_load_ff <= (state_ff == dci_pkg::ST_DO) && (cmd_ff == dci_pkg::CMD_WCNT)
                          && in_dbg;
            pc_load_ff   <= (state_ff == dci_pkg::ST_DO) && (cmd_ff == dci_pkg::CMD_WPC)
                          && cpu_ok;
            step_ff      <= (state_ff == dci_pkg::ST_DO) && (cmd_ff == dci_pkg::CMD_STEP)
                          && cpu_ok;
            stuff_ff     <= (state_ff == dci_pkg::ST_DO) && (cmd_ff == dci_pkg::CMD_STUFF)
                          && cpu_ok;
        end
    end

    // instruction bytes forwarded; length comes from the cpu opcode decoder
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            xrem_ff   <= 3'd0;
            xfirst_ff <= 1'b1;
        end else if (state_ff != dci_pkg::ST_EXEC) begin
            xfirst_ff <= 1'b1;
        end else if (rx_take) begin
            xfirst_ff <= 1'b0;
            xrem_ff   <= xfirst_ff ? exec_len - 3'd1 : xrem_ff - 3'd1;
        end
    end

    assign exec_valid           = (state_ff == dci_pkg::ST_EXEC) && rx_take && cpu_ok;
    assign exec_first           = xfirst_ff;
    assign exec_byte            = rx_data;
    assign cntr_load            = cntr_load_ff;
    assign cntr_wdata           = hdr_ff[15:0];
    assign pc_load              = pc_load_ff;
    assign pc_wdata             = hdr_ff[15:0];
    assign cpu_step             = step_ff;
    assign cpu_stuff            = stuff_ff;
    assign stuff_opcode         = hdr_ff[7:0];
    assign debug_halt_bit       = ctl_ff[dci_pkg::CTL_HALT_BIT];
    assign debugger_control_reg = ctl_ff;
    assign mem_we               = we_ff;
    assign mem_space            = space_ff;
    assign mem_addr             = addr_ff;
    assign mem_wdata            = wdat_ff;
endmodule : dci_interp

//--- sim/dci_mem_model.sv
// memory responder: even addresses ack at once, odd ones after a stall
module dci_mem_model (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic             mem_ack,
    output logic      [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_ff;
    wire        pend = mem_req && !mem_ack;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wait_ff <= 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
        end else begin
            wait_ff <= (pend && wait_ff < {mem_addr[0], 1'b0}) ? wait_ff + 2'h1 : 2'h0;
            mem_ack <= pend && wait_ff >= {mem_addr[0], 1'b0};
            // data toggles outside the ack so a stale byte is never seen
            mem_rdata <= (pend && wait_ff >= {mem_addr[0], 1'b0}) ? mem_addr[7:0] ^ 8'hA5
                                                                   : ~mem_rdata;
        end
    end
endmodule : dci_mem_model

//--- sim/dci_interp_props.sv
// port assertions for the debug command interpreter
module dci_interp_props (
    input wire logic clock, arst_n, rx_ready, tx_valid, tx_ready, read_protect_option,
    input wire logic cntr_load, pc_load, debug_halt_bit, cpu_step, exec_valid,
    input wire logic mem_req, mem_we, mem_ack,
    input wire logic [7:0] tx_data, debugger_control_reg,
    input wire logic [1:0] mem_space,
    input wire logic [15:0] mem_addr
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    property p_halt; debug_halt_bit == debugger_control_reg[dci_pkg::CTL_HALT_BIT]; endproperty
    a_halt: assert property (p_halt) else $error("halt bit differs from control");
    property p_cnt; cntr_load |-> debug_halt_bit; endproperty
    a_cnt: assert property (p_cnt) else $error("counter load outside debug");
    property p_pc; pc_load |-> debug_halt_bit && !read_protect_option; endproperty
    a_pc: assert property (p_pc) else $error("pc load while blocked");
    property p_run; cpu_step || exec_valid |-> debug_halt_bit && !read_protect_option; endproperty
    a_run: assert property (p_run) else $error("cpu action while blocked");
    property p_wr; mem_req && mem_we |-> debug_halt_bit
        && (!read_protect_option || mem_space == dci_pkg::SPACE_REG); endproperty
    a_wr: assert property (p_wr) else $error("memory write while blocked");
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("access dropped before ack");
    property p_tx; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    a_tx: assert property (p_tx) else $error("reply changed before taken");
    property p_busy; tx_valid |-> !rx_ready; endproperty
    a_busy: assert property (p_busy) else $error("input open while replying");
    c_tx: cover property (tx_valid && tx_ready);
    c_mem: cover property (mem_req && mem_ack);
    c_step: cover property (cpu_step);
endmodule : dci_interp_props
bind dci_interp dci_interp_props u_dci_interp_props (.*);

//--- sim/dci_interp_test.sv
// self-checking bench for the debug command interpreter
module dci_interp_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, arst_n = 0, link_break = 0, rx_valid = 0, tx_ready = 1;
    logic read_protect_option = 0, flash_unlocked = 0, cpu_idle = 0, cpu_halt_mode = 0;
    logic hw_halt_set = 0, rx_ready, tx_valid, cntr_load, pc_load, debug_halt_bit, cpu_step;
    logic cpu_stuff, exec_valid, exec_first, mem_req, mem_we, mem_ack;
    logic [2:0] exec_len = 3'h1;
    logic [1:0] mem_space;
    logic [7:0] rx_data = 8'h00, tx_data, debugger_control_reg, stuff_opcode, exec_byte;
    logic [7:0] mem_wdata, mem_rdata, exp_q[$];
    logic [31:0] seed = 32'h92ED;
    logic [15:0] cntr_wdata, pc_wdata, mem_addr;
    // fixed literals: initialisers must not depend on another variable's
    logic [15:0] program_counter = 16'h92ED, debug_down_counter = 16'h6D12;
    logic [15:0] baud_reload = 16'hED92;
    int n_mismatch = 0, n_checks = 0, n_step = 0;
    dci_interp #(.PROG_SIZE(16)) u_dci_interp (.*);
    dci_mem_model u_dci_mem_model (.clock, .arst_n, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
    always #4 clock = ~clock;
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // random back-pressure on replies, about one cycle in four
    always @(posedge clock) begin
        #1 seed = lfsr(seed);
        tx_ready = seed[0] | seed[3];
    end
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    task cmp_byte(input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH tx_data expected %h seen %h", e, s);
        end
    endtask : cmp_byte
    task cmp_count(input int e, input int s);
        n_checks++;
        if (s != e) begin
            n_mismatch++;
            $display("MISMATCH cpu_step expected %0d seen %0d", e, s);
        end
    endtask : cmp_count
    always @(posedge clock) if (cpu_step === 1'b1) n_step++;
    always @(posedge clock) if (tx_valid === 1'b1 && tx_ready === 1'b1)
        cmp_byte(exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, tx_data);
    task bound(input int i);
        if (i >= 4000) begin
            n_mismatch++;
            complete_run;
        end
    endtask : bound
    // whole command sent, then every reply byte collected before the next
    task cmd(input logic [7:0] c, input int na, input logic [31:0] a, input int ne,
             input logic [15:0] e);
        int i;
        int k;
        for (i = ne - 1; i >= 0; i--) exp_q.push_back(e[8*i +: 8]);
        rx_valid = 1'b1;
        for (k = na; k >= 0; k--) begin
            rx_data = (k == na) ? c : a[8*k +: 8];
            for (i = 0; i < 4000 && rx_ready !== 1'b1; i++) @(posedge clock) #1;
            bound(i);
            @(posedge clock) #1;
        end
        rx_valid = 1'b0;
        for (i = 0; i < 4000 && exp_q.size() > 0; i++) @(posedge clock) #1;
        bound(i);
        @(posedge clock) #1;
    endtask : cmd
    function logic [15:0] crc_exp;
        logic [15:0] c;
        logic [7:0] p;
        c = dci_pkg::CRC_SEED;
        for (int a = 0; a < 16; a++) begin
            p = a[7:0] ^ 8'hA5;
            for (int b = 0; b < 8; b++)
                c = (c >> 1) ^ ((c[0] ^ p[b]) ? dci_pkg::CRC_POLY_R : 16'h0000);
        end
        return ~c;
    endfunction : crc_exp
    initial begin
        repeat (4) @(posedge clock);
        #1 arst_n = 1'b1;
        cmd(8'h0F, 0, 0, 0, 0);
        cmd(dci_pkg::CMD_REV, 0, 0, 2, 16'h0100);
        cmd(dci_pkg::CMD_RCNT, 0, 0, 2, 16'hFFFF);
        cmd(dci_pkg::CMD_RPC, 0, 0, 2, 16'hFFFF);
        cmd(dci_pkg::CMD_WCTL, 1, 32'h80, 0, 0);
        link_break = 1'b1;
        @(posedge clock) #1 link_break = 1'b0;
        cmd(dci_pkg::CMD_RCTL, 0, 0, 1, 16'h0080);
        cmd(dci_pkg::CMD_RSTAT, 0, 0, 1, 16'h0080);
        cmd(dci_pkg::CMD_RCNT, 0, 0, 2, ~debug_down_counter);
        cmd(dci_pkg::CMD_RPC, 0, 0, 2, program_counter);
        cmd(dci_pkg::CMD_BAUD, 0, 0, 2, baud_reload);
        cmd(dci_pkg::CMD_RREG, 3, 32'h0F0102, 2, 16'hA4A7);
        cmd(dci_pkg::CMD_CRC, 0, 0, 2, crc_exp());
        cmd(dci_pkg::CMD_STEP, 0, 0, 0, 0);
        // the step strobe lags the command by a cycle; protect only after it
        @(posedge clock) #1 read_protect_option = 1'b1;
        cmp_count(1, n_step);
        cmd(dci_pkg::CMD_RSTAT, 0, 0, 1, 16'h00A0);
        cmd(dci_pkg::CMD_RPC, 0, 0, 2, 16'hFFFF);
        cmd(dci_pkg::CMD_RDATA, 4, 32'h00030001, 1, 16'h00A6);
        cmd(dci_pkg::CMD_RPROG, 4, 32'h00030001, 1, 16'h00FF);
        cmd(dci_pkg::CMD_STEP, 0, 0, 0, 0);
        @(posedge clock) #1 cmp_count(1, n_step);
        complete_run;
    end
endmodule : dci_interp_test
